//--- core/cssp_pkg.sv
`default_nettype none
package cssp_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BITS_PER_BYTE = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_PORT_C_ALT  = 10'h055;
  localparam logic [9:0] IDX_TIME_CONST  = 10'h0AB;
  localparam logic [9:0] IDX_DATA        = 10'h0D0;
  localparam logic [9:0] IDX_STATUS      = 10'h0D3;
  localparam logic [9:0] IDX_SERIAL_B    = 10'h0D4;
  localparam logic [9:0] IDX_SELECT_CTL  = 10'h0D5;

  localparam logic [7:0] PORT_C_ALT_MASK  = 8'h55;
  localparam logic [7:0] PORT_C_ALT_RESET = 8'h00;
  localparam int unsigned ALT_BIT_TXD = 0;
  localparam int unsigned ALT_BIT_TXC = 2;
  localparam int unsigned ALT_BIT_TXB = 4;
  localparam int unsigned ALT_BIT_TXA = 6;

  localparam logic [7:0] TIME_CONST_RESET = 8'h00;
  localparam logic [7:0] SERIAL_B_RESET   = 8'h00;
  localparam logic [7:0] SELECT_CTL_RESET = 8'h01;
  localparam logic [7:0] SERIAL_B_RD_MASK = 8'h3F;

  localparam int unsigned CMD_LSB   = 6;
  localparam int unsigned RXSEL_LSB = 4;
  localparam int unsigned MODE_LSB  = 2;

  localparam logic [1:0] CMD_NOP     = 2'h0;
  localparam logic [1:0] CMD_RECEIVE = 2'h1;
  localparam logic [1:0] CMD_SEND    = 2'h2;
  localparam logic [1:0] MODE_ASYNC8 = 2'h0;
  localparam logic [1:0] MODE_ASYNC7 = 2'h1;
  localparam logic [1:0] MODE_EXT    = 2'h2;
  localparam logic [1:0] MODE_INT    = 2'h3;
  localparam logic [1:0] RXSEL_C     = 2'h0;
  localparam logic [1:0] RXSEL_D     = 2'h1;

  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_RX_FULL = 1;
  localparam int unsigned ST_SS_ERR  = 2;
  localparam int unsigned ST_SS_LVL  = 3;

  localparam int unsigned SEL_LEVEL    = 0;
  localparam int unsigned SEL_AS_INPUT = 1;
  localparam int unsigned SEL_ROUTE_D  = 2;

  typedef enum logic [2:0] {
    CSSP_IDLE = 3'h1,
    CSSP_HIGH = 3'h2,
    CSSP_LOW  = 3'h4
  } cssp_state_t;

endpackage
`default_nettype wire

//--- core/cssp_port.sv
// How it works
// - Master makes eight clocks per byte
// - Bytes shift least significant bit first
// - Data changes on fall, sampled on rise
// - Master drives clock; slave takes it in
// - One bit out and one in per cycle
// - Select pin drives active-low slave select
// - Select pin may instead watch for errors
// - Serial port may use port C or port D
// - Alternate bit four routes serial output
// - Only even alternate bits are implemented
// - Bit four routes B, six routes A
// - Mode field picks async or clocked clock
// - Command field starts receive or transmit
// - Receive select picks C, D, or off
// - Rate timer counts modulo n plus one
`default_nettype none
module cssp_port
  import cssp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              serial_b_clock_pin_in,
  output logic                   serial_b_clock_pin_out,
  output logic                   serial_b_clock_pin_oe,
  input  wire logic              serial_b_receive_in,
  input  wire logic              serial_b_receive_alt_pin,
  output logic                   serial_b_transmit_alt_pin,
  input  wire logic              slave_select_in_n,
  output logic                   slave_select_out_n,
  output logic                   slave_select_oe,
  input  wire logic              serial_a_transmit_out,
  input  wire logic              serial_c_transmit_out,
  input  wire logic              serial_d_transmit_out,
  input  wire logic [7:0]        port_c_gpio_out,
  output logic [7:0]             port_c_pin_out
);

  typedef struct packed {
    logic [BYTE_W-1:0] alt_select;
    logic [BYTE_W-1:0] serial_ctl;
    logic [BYTE_W-1:0] time_const;
    logic [BYTE_W-1:0] select_ctl;
    logic [BYTE_W-1:0] tx_data;
    logic [BYTE_W-1:0] rx_data;
    logic              rx_full;
    logic              ss_err;
    logic              start;
    logic              send;
    logic [1:0]        sclk_sync;
    logic [1:0]        rxc_sync;
    logic [1:0]        rxd_sync;
    logic [1:0]        ss_sync;
    logic [7:0]        pin_c;
    logic              pin_alt_b;
    logic [31:0]       rdata;
  } cssp_top_t;

  cssp_top_t         cur_ff;
  cssp_top_t         nxt_cur;
  logic              eng_busy;
  logic              eng_done;
  logic [BYTE_W-1:0] eng_rx;
  logic              eng_sclk;
  logic              eng_tx;
  logic              tick;
  logic              master;
  logic              clocked;
  logic              rx_bit;
  logic              access;
  logic              mapped;
  logic              wr;
  logic              rd;
  logic [9:0]        idx;
  logic [1:0]        mode;
  logic [1:0]        rxsel;
  logic [7:0]        alt_src;

  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i == IDX_PORT_C_ALT) || (i == IDX_TIME_CONST) || (i == IDX_DATA) ||
                (i == IDX_STATUS) || (i == IDX_SERIAL_B) || (i == IDX_SELECT_CTL);
  endfunction

  assign idx     = paddr[ADDR_W-1:2];
  assign mapped  = is_mapped(idx);
  assign access  = psel & penable;
  assign wr      = access & pwrite & mapped;
  assign rd      = access & ~pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = cur_ff.rdata;

  assign mode    = cur_ff.serial_ctl[MODE_LSB+:2];
  assign rxsel   = cur_ff.serial_ctl[RXSEL_LSB+:2];
  assign master  = (mode == MODE_INT);
  assign clocked = (mode == MODE_INT) || (mode == MODE_EXT);

  always_comb
  begin
    // An off receiver sees an idle line rather than whatever sits on the pin.
    if (rxsel == RXSEL_C)
    begin
      rx_bit = cur_ff.rxc_sync[1];
    end
    else if (rxsel == RXSEL_D)
    begin
      rx_bit = cur_ff.rxd_sync[1];
    end
    else
    begin
      rx_bit = 1'b1;
    end
  end

  cssp_rate_timer u_timer (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .run        (master & eng_busy),
    .time_const (cur_ff.time_const),
    .tick       (tick)
  );

  cssp_shift_engine u_engine (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .start     (cur_ff.start),
    .send      (cur_ff.send),
    .master    (master),
    .tx_byte   (cur_ff.tx_data),
    .tick      (tick),
    .sclk_sync (cur_ff.sclk_sync[1]),
    .rx_bit    (rx_bit),
    .busy      (eng_busy),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .sclk_out  (eng_sclk),
    .tx_bit    (eng_tx)
  );

  always_comb
  begin
    alt_src = 8'h00;
    alt_src[ALT_BIT_TXA] = serial_a_transmit_out;
    alt_src[ALT_BIT_TXB] = cur_ff.select_ctl[SEL_ROUTE_D] ? 1'b1 : eng_tx;
    alt_src[ALT_BIT_TXC] = serial_c_transmit_out;
    alt_src[ALT_BIT_TXD] = serial_d_transmit_out;
  end

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.start = 1'b0;
    nxt_cur.sclk_sync = {cur_ff.sclk_sync[0], serial_b_clock_pin_in};
    nxt_cur.rxc_sync = {cur_ff.rxc_sync[0], serial_b_receive_in};
    nxt_cur.rxd_sync = {cur_ff.rxd_sync[0], serial_b_receive_alt_pin};
    nxt_cur.ss_sync = {cur_ff.ss_sync[0], slave_select_in_n};

    for (int i = 0; i < 8; i++)
    begin
      // Odd positions have no alternate source and stay plain port bits.
      nxt_cur.pin_c[i] = (PORT_C_ALT_MASK[i] & cur_ff.alt_select[i]) ?
                         alt_src[i] : port_c_gpio_out[i];
    end
    // A byte leaves on port D only when port C gave up that output.
    nxt_cur.pin_alt_b = cur_ff.select_ctl[SEL_ROUTE_D] ? eng_tx : 1'b1;

    if (psel & ~penable)
    begin
      nxt_cur.rdata = 32'h0000_0000;
      if (idx == IDX_PORT_C_ALT)
      begin
        nxt_cur.rdata[7:0] = cur_ff.alt_select & PORT_C_ALT_MASK;
      end
      else if (idx == IDX_TIME_CONST)
      begin
        nxt_cur.rdata[7:0] = cur_ff.time_const;
      end
      else if (idx == IDX_DATA)
      begin
        nxt_cur.rdata[7:0] = cur_ff.rx_data;
      end
      else if (idx == IDX_STATUS)
      begin
        nxt_cur.rdata[ST_BUSY] = eng_busy | cur_ff.start;
        nxt_cur.rdata[ST_RX_FULL] = cur_ff.rx_full;
        nxt_cur.rdata[ST_SS_ERR] = cur_ff.ss_err;
        nxt_cur.rdata[ST_SS_LVL] = cur_ff.ss_sync[1];
      end
      else if (idx == IDX_SERIAL_B)
      begin
        nxt_cur.rdata[7:0] = cur_ff.serial_ctl & SERIAL_B_RD_MASK;
      end
      else if (idx == IDX_SELECT_CTL)
      begin
        nxt_cur.rdata[7:0] = cur_ff.select_ctl;
      end
    end

    // Reads clear flags first so a same-cycle hardware set below wins.
    if (rd && idx == IDX_DATA)
    begin
      nxt_cur.rx_full = 1'b0;
    end
    if (rd && idx == IDX_STATUS)
    begin
      nxt_cur.ss_err = 1'b0;
    end

    if (wr)
    begin
      if (idx == IDX_PORT_C_ALT)
      begin
        nxt_cur.alt_select = pwdata[7:0] & PORT_C_ALT_MASK;
      end
      else if (idx == IDX_TIME_CONST)
      begin
        nxt_cur.time_const = pwdata[7:0];
      end
      else if (idx == IDX_DATA)
      begin
        // The shifter owns the byte while it runs, so late writes are dropped.
        if (!eng_busy && !cur_ff.start)
        begin
          nxt_cur.tx_data = pwdata[7:0];
        end
      end
      else if (idx == IDX_SERIAL_B)
      begin
        nxt_cur.serial_ctl = pwdata[7:0] & SERIAL_B_RD_MASK;
        if (!eng_busy && !cur_ff.start && (pwdata[3:2] == MODE_INT ||
            pwdata[3:2] == MODE_EXT))
        begin
          if (pwdata[CMD_LSB+:2] == CMD_SEND)
          begin
            nxt_cur.start = 1'b1;
            nxt_cur.send = 1'b1;
          end
          else if (pwdata[CMD_LSB+:2] == CMD_RECEIVE)
          begin
            nxt_cur.start = 1'b1;
            nxt_cur.send = 1'b0;
          end
        end
      end
      else if (idx == IDX_SELECT_CTL)
      begin
        nxt_cur.select_ctl = pwdata[7:0] & 8'h07;
      end
    end

    if (eng_done)
    begin
      nxt_cur.rx_data = eng_rx;
      nxt_cur.rx_full = 1'b1;
    end
    if (clocked && cur_ff.select_ctl[SEL_AS_INPUT] && !cur_ff.ss_sync[1])
    begin
      nxt_cur.ss_err = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cur_ff <= '{alt_select: PORT_C_ALT_RESET, serial_ctl: SERIAL_B_RESET,
                  time_const: TIME_CONST_RESET, select_ctl: SELECT_CTL_RESET,
                  tx_data: 8'h00, rx_data: 8'h00, rx_full: 1'b0, ss_err: 1'b0,
                  start: 1'b0, send: 1'b0, sclk_sync: 2'h3, rxc_sync: 2'h3,
                  rxd_sync: 2'h3, ss_sync: 2'h3, pin_c: 8'h00, pin_alt_b: 1'b1,
                  rdata: 32'h0000_0000};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign serial_b_clock_pin_out    = eng_sclk;
  assign serial_b_clock_pin_oe     = master;
  assign serial_b_transmit_alt_pin = cur_ff.pin_alt_b;
  assign port_c_pin_out            = cur_ff.pin_c;
  assign slave_select_out_n        = cur_ff.select_ctl[SEL_LEVEL];
  assign slave_select_oe           = ~cur_ff.select_ctl[SEL_AS_INPUT];

endmodule
`default_nettype wire

//--- core/cssp_rate_timer.sv
`default_nettype none
module cssp_rate_timer
  import cssp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              run,
  input  wire logic [BYTE_W-1:0] time_const,
  output logic                   tick
);

  typedef struct packed {
    logic [BYTE_W-1:0] count;
    logic              tick;
  } cssp_timer_t;

  cssp_timer_t cur_ff;
  cssp_timer_t nxt_cur;

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.tick = 1'b0;
    if (!run)
    begin
      nxt_cur.count = time_const;
    end
    else if (cur_ff.count == '0)
    begin
      // A constant written mid-count is only picked up here.
      nxt_cur.count = time_const;
      nxt_cur.tick = 1'b1;
    end
    else
    begin
      nxt_cur.count = cur_ff.count - 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign tick = cur_ff.tick;

endmodule
`default_nettype wire

//--- core/cssp_shift_engine.sv
`default_nettype none
module cssp_shift_engine
  import cssp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              start,
  input  wire logic              send,
  input  wire logic              master,
  input  wire logic [BYTE_W-1:0] tx_byte,
  input  wire logic              tick,
  input  wire logic              sclk_sync,
  input  wire logic              rx_bit,
  output logic                   busy,
  output logic                   done,
  output logic [BYTE_W-1:0]      rx_byte,
  output logic                   sclk_out,
  output logic                   tx_bit
);

  typedef struct packed {
    cssp_state_t       state;
    logic [BYTE_W-1:0] shift;
    logic [3:0]        count;
    logic              send;
    logic              sclk_prev;
    logic              sclk;
    logic              tx;
    logic              done;
    logic [BYTE_W-1:0] rx;
  } cssp_engine_t;

  cssp_engine_t cur_ff;
  cssp_engine_t nxt_cur;
  logic         fall;
  logic         rise;

  // Master edges come from the rate timer, slave edges from the sampled pin.
  assign fall = master ? tick : (cur_ff.sclk_prev & ~sclk_sync);
  assign rise = master ? tick : (~cur_ff.sclk_prev & sclk_sync);

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.sclk_prev = sclk_sync;
    case (cur_ff.state)
      CSSP_IDLE:
      begin
        nxt_cur.sclk = 1'b1;
        if (start)
        begin
          nxt_cur.shift = send ? tx_byte : 8'hFF;
          nxt_cur.send = send;
          nxt_cur.count = 4'h0;
          nxt_cur.state = CSSP_HIGH;
        end
      end
      CSSP_HIGH:
      begin
        if (fall)
        begin
          // A slave leaves its undriven clock output at the idle level.
          nxt_cur.sclk = ~master;
          nxt_cur.tx = cur_ff.send ? cur_ff.shift[0] : 1'b1;
          nxt_cur.state = CSSP_LOW;
        end
      end
      CSSP_LOW:
      begin
        if (rise)
        begin
          nxt_cur.sclk = 1'b1;
          // One bit leaves and one enters on every clock cycle.
          nxt_cur.shift = {rx_bit, cur_ff.shift[BYTE_W-1:1]};
          nxt_cur.count = cur_ff.count + 4'h1;
          if (cur_ff.count == 4'(BITS_PER_BYTE - 1))
          begin
            nxt_cur.rx = {rx_bit, cur_ff.shift[BYTE_W-1:1]};
            nxt_cur.done = 1'b1;
            nxt_cur.tx = 1'b1;
            nxt_cur.state = CSSP_IDLE;
          end
          else
          begin
            nxt_cur.state = CSSP_HIGH;
          end
        end
      end
      default:
      begin
        nxt_cur.state = CSSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cur_ff <= '{state: CSSP_IDLE, shift: 8'h00, count: 4'h0, send: 1'b0,
                  sclk_prev: 1'b1, sclk: 1'b1, tx: 1'b1, done: 1'b0, rx: 8'h00};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign busy     = (cur_ff.state != CSSP_IDLE);
  assign done     = cur_ff.done;
  assign rx_byte  = cur_ff.rx;
  assign sclk_out = cur_ff.sclk;
  assign tx_bit   = cur_ff.tx;

endmodule
`default_nettype wire

//--- tb/cssp_port_monitor.sv
`default_nettype none
module cssp_port_monitor
  import cssp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_b_clock_pin_out,
  input wire logic        serial_b_clock_pin_oe,
  input wire logic        serial_b_transmit_alt_pin,
  input wire logic        slave_select_out_n,
  input wire logic        slave_select_oe,
  input wire logic        serial_a_transmit_out,
  input wire logic        serial_c_transmit_out,
  input wire logic        serial_d_transmit_out,
  input wire logic [7:0]  port_c_gpio_out,
  input wire logic [7:0]  port_c_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_setup_quiet: assert property (psel && !penable |-> !pslverr)
    else $error("error flag raised in setup cycle");
  a_access_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_clk_master: assert property ($fell(serial_b_clock_pin_out) |-> serial_b_clock_pin_oe)
    else $error("clock toggled while not master");
  a_reset_state: assert property ($rose(reset_n) |-> serial_b_clock_pin_out &&
    !serial_b_clock_pin_oe && slave_select_out_n && slave_select_oe && serial_b_transmit_alt_pin)
    else $error("wrong pin state after reset");
  a_odd_gpio: assert property ($past(reset_n) |->
    {port_c_pin_out[7], port_c_pin_out[5], port_c_pin_out[3], port_c_pin_out[1]} ==
    $past({port_c_gpio_out[7], port_c_gpio_out[5], port_c_gpio_out[3], port_c_gpio_out[1]}))
    else $error("odd port pin not plain output");
  a_alt_source: assert property ($past(reset_n) |->
    (port_c_pin_out[6] == $past(serial_a_transmit_out) || port_c_pin_out[6] == $past(port_c_gpio_out[6]))
    && (port_c_pin_out[2] == $past(serial_c_transmit_out) || port_c_pin_out[2] == $past(port_c_gpio_out[2]))
    && (port_c_pin_out[0] == $past(serial_d_transmit_out) || port_c_pin_out[0] == $past(port_c_gpio_out[0])))
    else $error("port pin from wrong source");
endmodule
`default_nettype wire

//--- tb/cssp_port_tb.sv
`default_nettype none
module cssp_port_tb;
  import cssp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_ALT = {IDX_PORT_C_ALT, 2'h0};
  localparam logic [11:0] A_TC  = {IDX_TIME_CONST, 2'h0};
  localparam logic [11:0] A_DAT = {IDX_DATA, 2'h0};
  localparam logic [11:0] A_ST  = {IDX_STATUS, 2'h0};
  localparam logic [11:0] A_SB  = {IDX_SERIAL_B, 2'h0};
  localparam logic [11:0] A_SEL = {IDX_SELECT_CTL, 2'h0};
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        serial_b_clock_pin_in, serial_b_clock_pin_out, serial_b_clock_pin_oe;
  logic        serial_b_receive_in, serial_b_receive_alt_pin, serial_b_transmit_alt_pin;
  logic        slave_select_in_n, slave_select_out_n, slave_select_oe;
  logic        serial_a_transmit_out, serial_c_transmit_out, serial_d_transmit_out;
  logic [7:0]  port_c_gpio_out, port_c_pin_out, s_tx, s_rx, tx, rb, cmd, alt, got;
  logic [7:0]  exp_q[$];
  int          fails, num_checks, s_falls;
  cssp_port u_cssp_port (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_b_clock_pin_in, .serial_b_clock_pin_out, .serial_b_clock_pin_oe,
    .serial_b_receive_in, .serial_b_receive_alt_pin, .serial_b_transmit_alt_pin,
    .slave_select_in_n, .slave_select_out_n, .slave_select_oe, .serial_a_transmit_out,
    .serial_c_transmit_out, .serial_d_transmit_out, .port_c_gpio_out, .port_c_pin_out);
  cssp_spi_slave u_cssp_spi_slave (.sclk(serial_b_clock_pin_out), .sel_n(slave_select_out_n),
    .mosi(port_c_pin_out[4]), .tx_byte(s_tx), .miso(serial_b_receive_in), .rx_byte(s_rx));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(negedge serial_b_clock_pin_out)
    s_falls++;
  task automatic stop_test(input int add);
    fails += add;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 50)
      stop_test(1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_ST, 8'h00);
      n++;
    end
    while (rdat[ST_BUSY] !== 1'b0 && n < 200);
    if (n == 200)
      stop_test(1);
  endtask
  initial
  begin
    {psel, penable, pwrite, reset_n} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {serial_b_clock_pin_in, serial_b_receive_alt_pin, slave_select_in_n} = 3'h7;
    {serial_a_transmit_out, serial_c_transmit_out, serial_d_transmit_out} = 3'h0;
    port_c_gpio_out = 8'h00;
    s_tx = 8'h00;
    fails = 0;
    num_checks = 0;
    s_falls = 0;
    void'($urandom(32'hBBFA));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, A_ALT, 8'h00);
    chk("alt reset", rdat, 32'h0);
    apb(1'b0, A_SEL, 8'h00);
    chk("select reset", rdat, {24'h0, SELECT_CTL_RESET});
    apb(1'b1, A_ALT, 8'hFF);
    apb(1'b0, A_ALT, 8'h00);
    chk("alt implemented", rdat, {24'h0, PORT_C_ALT_MASK});
    apb(1'b0, 12'h004, 8'h00);
    chk("unmapped error", rerr, 1'b1);
    $display("test registers done");
    for (int k = 0; k < 4; k++)
    begin
      alt = k[0] ? 8'h55 : 8'h00;
      apb(1'b1, A_ALT, alt);
      port_c_gpio_out <= 8'($urandom);
      {serial_a_transmit_out, serial_c_transmit_out, serial_d_transmit_out} <= 3'($urandom);
      repeat (2) @(posedge mclk);
      rb = {1'b0, serial_a_transmit_out, 3'b010, serial_c_transmit_out, 1'b0, serial_d_transmit_out};
      chk("port pins", port_c_pin_out, (port_c_gpio_out & ~alt) | (alt & rb));
    end
    $display("test routing done");
    apb(1'b1, A_ALT, 8'h50);
    apb(1'b1, A_TC, 8'h04);
    apb(1'b1, A_SEL, 8'h00);
    chk("select low", {slave_select_out_n, slave_select_oe}, 2'b01);
    for (int k = 0; k < 4; k++)
    begin
      cmd = (k == 0) ? 8'h8C : (k == 1) ? 8'h4C : (k == 2) ? 8'h80 : 8'hAC;
      tx = 8'($urandom);
      rb = 8'($urandom);
      s_tx <= rb;
      s_falls = 0;
      apb(1'b1, A_DAT, tx);
      apb(1'b1, A_SB, cmd);
      wait_idle;
      chk("clock falls", s_falls, cmd[2] ? 8 : 0);
      if (cmd[2])
      begin
        exp_q.push_back(cmd[5] ? 8'hFF : rb);
        chk("slave got", s_rx, cmd[7] ? tx : 8'hFF);
        apb(1'b0, A_ST, 8'h00);
        chk("rx full", rdat[ST_RX_FULL], 1'b1);
        apb(1'b0, A_DAT, 8'h00);
        chk("rx byte", rdat, exp_q.pop_front());
        apb(1'b0, A_ST, 8'h00);
        chk("rx cleared", rdat[ST_RX_FULL], 1'b0);
      end
    end
    apb(1'b1, A_SEL, 8'h01);
    chk("select high", slave_select_out_n, 1'b1);
    $display("test master done");
    apb(1'b1, A_SEL, 8'h05);
    tx = 8'($urandom);
    rb = 8'($urandom);
    exp_q.push_back(rb);
    apb(1'b1, A_DAT, tx);
    apb(1'b1, A_SB, 8'h98);
    chk("clock not driven", serial_b_clock_pin_oe, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      serial_b_clock_pin_in <= 1'b0;
      serial_b_receive_alt_pin <= rb[i];
      repeat (4) @(posedge mclk);
      serial_b_clock_pin_in <= 1'b1;
      repeat (4) @(posedge mclk);
      got[i] = serial_b_transmit_alt_pin;
    end
    serial_b_receive_alt_pin <= ~rb[7];
    chk("port c held", port_c_pin_out[4], 1'b1);
    wait_idle;
    chk("slave tx", got, tx);
    apb(1'b0, A_DAT, 8'h00);
    chk("slave rx", rdat, exp_q.pop_front());
    $display("test slave done");
    apb(1'b1, A_SEL, 8'h02);
    chk("select input", slave_select_oe, 1'b0);
    slave_select_in_n <= 1'b0;
    repeat (4) @(posedge mclk);
    apb(1'b0, A_ST, 8'h00);
    chk("select error", rdat[ST_SS_ERR], 1'b1);
    chk("select level", rdat[ST_SS_LVL], 1'b0);
    slave_select_in_n <= 1'b1;
    $display("test select input done");
    stop_test(0);
  end
endmodule
bind cssp_port cssp_port_monitor u_cssp_port_monitor (.mclk, .reset_n, .psel, .penable,
  .prdata, .pready, .pslverr, .serial_b_clock_pin_out, .serial_b_clock_pin_oe,
  .serial_b_transmit_alt_pin, .slave_select_out_n, .slave_select_oe, .serial_a_transmit_out,
  .serial_c_transmit_out, .serial_d_transmit_out, .port_c_gpio_out, .port_c_pin_out);
`default_nettype wire

//--- tb/cssp_spi_slave.sv
`default_nettype none
module cssp_spi_slave (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] nb;
  initial
  begin
    miso = 1'b1;
    rx_byte = 8'h00;
    nb = 3'h0;
  end
  // The index wraps every eight clocks, so bytes stay framed while select stays low.
  // A released line shows the inverse of its last bit, so a stale value cannot pass.
  always @(negedge sclk or posedge sel_n)
    if (sel_n)
      miso = ~miso;
    else
      miso = tx_byte[nb];
  always @(posedge sclk)
    if (!sel_n)
    begin
      rx_byte[nb] = mosi;
      nb = nb + 3'h1;
    end
endmodule
`default_nettype wire
